/* src/dadi_pkg.sv */
/*
  Shared constants and types of the decimal adjust, decrement and
  global interrupt enable execution block.
  Assumes one core clock; the register file and fetch pipeline sit outside.
*/
package dadi_pkg;

  // Instruction selector, one-hot
  typedef enum logic [6:0] {
    OP_NONE = 7'h01,
    OP_ADD_ACC_REG = 7'h02,
    OP_DECIMAL_ADJUST_ACC = 7'h04,
    OP_DECREMENT_REG = 7'h08,
    OP_DECREMENT_SKIP_ZERO = 7'h10,
    OP_GLOBAL_IRQ_OFF = 7'h20,
    OP_GLOBAL_IRQ_ON = 7'h40
  } dadi_op_e;

  // Execution slot state, one-hot
  typedef enum logic [1:0] {
    ST_EXEC = 2'h1,
    ST_SKIP = 2'h2
  } dadi_st_e;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned RADDR_W = 4;

  // Software register indices
  localparam logic [3:0] REG_ACC = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_GIE = 4'h2;

  // Status field positions
  localparam int unsigned STAT_Z_POS = 0;
  localparam int unsigned STAT_C_POS = 1;
  localparam int unsigned STAT_HC_POS = 2;

  // Values after reset
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic GIE_RST = 1'b0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [6:0] RF_ADDR_RST = 7'h00;
  localparam logic [7:0] RF_DATA_RST = 8'h00;
  localparam logic READY_RST = 1'b1;
  localparam logic PULSE_RST = 1'b0;

  // Decimal adjust constants
  localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
  localparam logic [3:0] BCD_FIX = 4'h6;

  // Cycles of the skip slot
  localparam int unsigned SKIP_CYCLES = 1;

  // Digit above nine
  function automatic logic digit_over(input logic [3:0] d);
    digit_over = (d > BCD_MAX_DIGIT);
  endfunction

  // Byte equal to zero
  function automatic logic byte_zero(input logic [7:0] v);
    byte_zero = (v == 8'h00);
  endfunction

endpackage

/* src/dadi_alu_if.sv */
/*
  Carrier between the executor and its two arithmetic units.
  Assumes all members are combinational within one clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface dadi_alu_if;
  logic [7:0] acc;
  logic hc;
  logic c;
  logic [7:0] bcd_res;
  logic bcd_c;
  logic [7:0] opnd;
  logic [7:0] dec_res;
  logic dec_zero;

  modport core (output acc, hc, c, opnd, input bcd_res, bcd_c, dec_res, dec_zero);
  modport bcd (input acc, hc, c, output bcd_res, bcd_c);
  modport dec (input opnd, output dec_res, dec_zero);
endinterface
`default_nettype wire

/* src/dadi_bcd_adj.sv */
/*
  Combinational decimal adjust of the accumulator.
  Assumes the flags come from the addition just before.
*/
`timescale 1ns/100ps
`default_nettype none
module dadi_bcd_adj (
  dadi_alu_if.bcd alu
);
  import dadi_pkg::*;

  wire fix_lo;
  wire [8:0] lo_sum;
  wire fix_hi;
  wire [8:0] hi_sum;

  // Low digit fix, then high digit fix
  assign fix_lo = digit_over(alu.acc[3:0]) | alu.hc; // RL10
  assign lo_sum = {1'b0, alu.acc} + (fix_lo ? {5'h00, BCD_FIX} : 9'h000);
  assign fix_hi = digit_over(lo_sum[7:4]) | alu.c | lo_sum[8]; // RL10
  assign hi_sum = {1'b0, lo_sum[7:0]} + (fix_hi ? {1'b0, BCD_FIX, 4'h0} : 9'h000);
  assign alu.bcd_res = hi_sum[7:0];
  assign alu.bcd_c = fix_hi | hi_sum[8]; // RL10
endmodule
`default_nettype wire

/* src/dadi_dec_unit.sv */
/*
  Combinational decrement of a file register value with zero detect.
  Assumes the operand is the value read from the addressed register.
*/
`timescale 1ns/100ps
`default_nettype none
module dadi_dec_unit (
  dadi_alu_if.dec alu
);
  import dadi_pkg::*;

  assign alu.dec_res = alu.opnd - 8'h01;
  assign alu.dec_zero = byte_zero(alu.dec_res);
endmodule
`default_nettype wire

/* src/dadi_core.sv */
/*
  Executor for the addition, decimal adjust, decrement, decrement with
  skip, and global interrupt off/on instructions, with a small software
  register port for accumulator, status flags and interrupt enable.
  Assumes the issuing core presents the file register value already read,
  and that the fetch stage honours the discard pulse.
*/
// Added by the designer: strobed register access and the address map.
// Functional notes
// RL1: Decimal adjust converts accumulator, sets carry, 1 cycle
// RL2: Program places adjust right after the addition
// RL3: Program should mask interrupts around add and adjust
// RL4: Decrement-skip writes accumulator (d=0) or register (d=1)
// RL5: Zero result discards fetched instruction, runs no-op
// RL6: Decrement-skip takes one cycle, two when skipping
// RL7: Decrement routes by destination, updates zero, 1 cycle
// RL8: Interrupt off clears global enable in one cycle
// RL9: Interrupt on sets global enable to one
// RL10: Add six per nibble over nine or carried
// RL11: File operand address is seven bits, 0..127
`timescale 1ns/100ps
`default_nettype none
module dadi_core (
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_op_valid,
  input wire dadi_pkg::dadi_op_e i_op,
  input wire logic [dadi_pkg::FADDR_W-1:0] i_reg_addr,
  input wire logic i_dest,
  input wire logic [dadi_pkg::DATA_W-1:0] i_reg_val,
  input wire logic [dadi_pkg::RADDR_W-1:0] i_sw_addr,
  input wire logic [dadi_pkg::DATA_W-1:0] i_sw_wdata,
  input wire logic i_sw_we,
  input wire logic i_sw_re,
  output logic [dadi_pkg::DATA_W-1:0] o_sw_rdata,
  output logic [dadi_pkg::DATA_W-1:0] o_acc,
  output logic o_flag_z,
  output logic o_flag_c,
  output logic o_flag_hc,
  output logic o_gie,
  output logic o_rf_we,
  output logic [dadi_pkg::FADDR_W-1:0] o_rf_addr,
  output logic [dadi_pkg::DATA_W-1:0] o_rf_wdata,
  output logic o_ready,
  output logic o_discard
);
  import dadi_pkg::*;

  dadi_alu_if alu ();

  dadi_bcd_adj u_bcd (
    .alu(alu)
  );

  dadi_dec_unit u_dec (
    .alu(alu)
  );

  logic [7:0] acc_q;
  logic [7:0] acc_d;
  logic z_q;
  logic z_d;
  logic c_q;
  logic c_d;
  logic hc_q;
  logic hc_d;
  logic gie_q;
  logic gie_d;
  logic rf_we_q;
  logic [6:0] rf_addr_q;
  logic [7:0] rf_wdata_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  dadi_st_e st_q;
  dadi_st_e st_d;
  logic ready_q;
  logic discard_q;

  wire take;
  wire is_add;
  wire is_daa;
  wire is_dec;
  wire is_dsz;
  wire is_off;
  wire is_on;
  wire any_dec;
  wire [8:0] add_sum;
  wire add_hc;
  wire skip_now;
  wire to_acc;
  wire to_reg;
  wire [7:0] op_res;
  wire sw_acc_we;
  wire sw_stat_we;
  wire sw_gie_we;

  // Operand routing into the arithmetic units
  assign alu.acc = acc_q;
  assign alu.hc = hc_q;
  assign alu.c = c_q;
  assign alu.opnd = i_reg_val;

  // Instruction decode; nothing is taken in the discarded slot
  assign take = i_op_valid & ready_q; // RL5
  assign is_add = take & (i_op == OP_ADD_ACC_REG);
  assign is_daa = take & (i_op == OP_DECIMAL_ADJUST_ACC);
  assign is_dec = take & (i_op == OP_DECREMENT_REG);
  assign is_dsz = take & (i_op == OP_DECREMENT_SKIP_ZERO);
  assign is_off = take & (i_op == OP_GLOBAL_IRQ_OFF);
  assign is_on = take & (i_op == OP_GLOBAL_IRQ_ON);
  assign any_dec = is_dec | is_dsz;

  // Binary addition that feeds the decimal adjust
  assign add_sum = {1'b0, acc_q} + {1'b0, i_reg_val};
  assign add_hc = ({1'b0, acc_q[3:0]} + {1'b0, i_reg_val[3:0]}) > 5'h0f;

  assign op_res = any_dec ? alu.dec_res : add_sum[7:0];
  assign to_acc = (any_dec | is_add) & ~i_dest; // RL4 RL7
  assign to_reg = (any_dec | is_add) & i_dest; // RL4 RL7
  assign skip_now = is_dsz & alu.dec_zero; // RL5

  // Software register strobes
  assign sw_acc_we = i_sw_we & (i_sw_addr == REG_ACC);
  assign sw_stat_we = i_sw_we & (i_sw_addr == REG_STATUS);
  assign sw_gie_we = i_sw_we & (i_sw_addr == REG_GIE);

  // Accumulator; instruction result wins over a software write
  always_comb begin
    acc_d = acc_q;
    if (sw_acc_we) begin
      acc_d = i_sw_wdata;
    end
    if (is_daa) begin
      acc_d = alu.bcd_res; // RL1
    end else if (to_acc) begin
      acc_d = op_res;
    end
  end

  // Flags; hardware update wins over a software write
  always_comb begin
    z_d = z_q;
    c_d = c_q;
    hc_d = hc_q;
    if (sw_stat_we) begin
      z_d = i_sw_wdata[STAT_Z_POS];
      c_d = i_sw_wdata[STAT_C_POS];
      hc_d = i_sw_wdata[STAT_HC_POS];
    end
    if (is_add) begin
      z_d = byte_zero(add_sum[7:0]);
      c_d = add_sum[8];
      hc_d = add_hc;
    end else if (is_daa) begin
      c_d = alu.bcd_c; // RL1
    end else if (is_dec) begin
      z_d = alu.dec_zero; // RL7
    end
  end

  // Global interrupt enable
  always_comb begin
    gie_d = gie_q;
    if (sw_gie_we) begin
      gie_d = i_sw_wdata[0];
    end
    if (is_off) begin
      gie_d = 1'b0; // RL8
    end else if (is_on) begin
      gie_d = 1'b1; // RL9
    end
  end

  // Slot state
  always_comb begin
    case (st_q)
      ST_EXEC: st_d = skip_now ? ST_SKIP : ST_EXEC; // RL6
      ST_SKIP: st_d = ST_EXEC; // RL6
      default: st_d = ST_EXEC;
    endcase
  end

  // Read data
  always_comb begin
    rdata_d = RDATA_RST;
    if (i_sw_re) begin
      case (i_sw_addr)
        REG_ACC: rdata_d = acc_q;
        REG_STATUS: rdata_d = {5'h00, hc_q, c_q, z_q};
        REG_GIE: rdata_d = {7'h00, gie_q};
        default: rdata_d = RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      acc_q <= ACC_RST;
      z_q <= FLAG_RST;
      c_q <= FLAG_RST;
      hc_q <= FLAG_RST;
      gie_q <= GIE_RST;
    end else begin
      acc_q <= acc_d;
      z_q <= z_d;
      c_q <= c_d;
      hc_q <= hc_d;
      gie_q <= gie_d;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rf_we_q <= PULSE_RST;
      rf_addr_q <= RF_ADDR_RST;
      rf_wdata_q <= RF_DATA_RST;
    end else begin
      rf_we_q <= to_reg; // RL4 RL7
      rf_addr_q <= i_reg_addr; // RL11
      rf_wdata_q <= op_res;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      st_q <= ST_EXEC;
      ready_q <= READY_RST;
      discard_q <= PULSE_RST;
      rdata_q <= RDATA_RST;
    end else begin
      st_q <= st_d;
      ready_q <= (st_d == ST_EXEC); // RL6
      discard_q <= skip_now; // RL5
      rdata_q <= rdata_d;
    end
  end

  assign o_acc = acc_q;
  assign o_flag_z = z_q;
  assign o_flag_c = c_q;
  assign o_flag_hc = hc_q;
  assign o_gie = gie_q;
  assign o_rf_we = rf_we_q;
  assign o_rf_addr = rf_addr_q;
  assign o_rf_wdata = rf_wdata_q;
  assign o_ready = ready_q;
  assign o_discard = discard_q;
  assign o_sw_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_dsz_zero;
    is_dsz && alu.dec_zero;
  endsequence

  sequence s_skip_slot;
    !o_ready && o_discard ##1 o_ready && !o_discard;
  endsequence

  property p_daa_digits;
    is_daa && !hc_q && !c_q && !digit_over(acc_q[3:0]) && !digit_over(acc_q[7:4])
      |=> o_acc == $past(acc_q) && !o_flag_c;
  endproperty
  a_daa_digits: assert property (p_daa_digits) else $error("adjust altered a valid decimal byte"); // RL1

  property p_daa_fix_lo;
    is_daa && digit_over(acc_q[3:0]) && !hc_q
      |=> !digit_over(o_acc[3:0]) && o_acc[3:0] == $past(acc_q[3:0]) + 4'h6;
  endproperty
  a_daa_fix_lo: assert property (p_daa_fix_lo) else $error("low digit not corrected by six"); // RL10

  property p_daa_carry;
    is_daa && c_q |=> o_flag_c && o_flag_z == $past(z_q);
  endproperty
  a_daa_carry: assert property (p_daa_carry) else $error("adjust lost carry or touched zero"); // RL1

  property p_dsz_dest_reg;
    is_dsz && i_dest |=> o_rf_we && o_rf_wdata == $past(i_reg_val) - 8'h01
      && o_acc == $past(acc_q);
  endproperty
  a_dsz_dest_reg: assert property (p_dsz_dest_reg) else $error("skip decrement not written back"); // RL4

  property p_dsz_dest_acc;
    is_dsz && !i_dest |=> !o_rf_we && o_acc == $past(i_reg_val) - 8'h01;
  endproperty
  a_dsz_dest_acc: assert property (p_dsz_dest_acc) else $error("skip decrement not in accumulator"); // RL4

  property p_skip;
    s_dsz_zero |=> s_skip_slot;
  endproperty
  a_skip: assert property (p_skip) else $error("zero result did not skip one slot"); // RL5

  property p_no_skip;
    is_dsz && !alu.dec_zero |=> o_ready && !o_discard;
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("non-zero result stalled"); // RL6

  property p_dec_zero;
    is_dec |=> o_flag_z == ($past(i_reg_val) == 8'h01);
  endproperty
  a_dec_zero: assert property (p_dec_zero) else $error("decrement zero flag wrong"); // RL7

  property p_dec_addr;
    is_dec && i_dest |=> o_rf_we && o_rf_addr == $past(i_reg_addr);
  endproperty
  a_dec_addr: assert property (p_dec_addr) else $error("decrement wrote wrong address"); // RL11

  property p_irq_off;
    is_off |=> !o_gie;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("interrupt enable not cleared"); // RL8

  property p_irq_on;
    is_on |=> o_gie;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("interrupt enable not set"); // RL9

  property p_slot_ignored;
    !o_ready |=> $stable(o_gie) || $past(sw_gie_we);
  endproperty
  a_slot_ignored: assert property (p_slot_ignored) else $error("instruction ran in skip slot"); // RL5

endmodule
`default_nettype wire

/* testbench/dadi_tb.sv */
/*
  Self-checking bench for the decimal adjust, decrement and global
  interrupt enable executor: random and corner stimulus, expected values
  worked out here.
  Assumes dadi_pkg and the design files are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import dadi_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_op_valid = 1'b0;
  dadi_op_e i_op = OP_NONE;
  logic [6:0] i_reg_addr = 7'h00;
  logic i_dest = 1'b0;
  logic [7:0] i_reg_val = 8'h00;
  logic [3:0] i_sw_addr = 4'h0;
  logic [7:0] i_sw_wdata = 8'h00;
  logic i_sw_we = 1'b0;
  logic i_sw_re = 1'b0;
  logic [7:0] o_sw_rdata;
  logic [7:0] o_acc;
  logic o_flag_z;
  logic o_flag_c;
  logic o_flag_hc;
  logic o_gie;
  logic o_rf_we;
  logic [6:0] o_rf_addr;
  logic [7:0] o_rf_wdata;
  logic o_ready;
  logic o_discard;
  int miscompares = 0;
  int num_checks = 0;
  int ca[4] = '{28, 99, 9, 8};
  int cb[4] = '{25, 99, 1, 9};

  dadi_core dut (
    .i_ref_clk, .i_rstn, .i_op_valid, .i_op, .i_reg_addr, .i_dest, .i_reg_val,
    .i_sw_addr, .i_sw_wdata, .i_sw_we, .i_sw_re, .o_sw_rdata, .o_acc, .o_flag_z,
    .o_flag_c, .o_flag_hc, .o_gie, .o_rf_we, .o_rf_addr, .o_rf_wdata, .o_ready,
    .o_discard
  );

  always #4 i_ref_clk = ~i_ref_clk;

  function automatic logic [7:0] to_bcd(input int n);
    to_bcd = {4'(n / 10), 4'(n % 10)};
  endfunction

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Drive one instruction for one cycle, then settle past its result edge
  task automatic issue(input dadi_op_e op, input logic [7:0] v, input logic [6:0] a,
                       input logic d);
    @(posedge i_ref_clk);
    i_op_valid <= 1'b1;
    i_op <= op;
    i_reg_val <= v;
    i_reg_addr <= a;
    i_dest <= d;
    @(posedge i_ref_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask

  // Two instructions on consecutive cycles
  task automatic issue2(input dadi_op_e op1, input dadi_op_e op2, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_op_valid <= 1'b1;
    i_op <= op1;
    i_reg_val <= v;
    i_dest <= 1'b0;
    @(posedge i_ref_clk);
    i_op <= op2;
    @(posedge i_ref_clk);
    i_op_valid <= 1'b0;
    #1;
  endtask

  task automatic sw_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_sw_we <= 1'b1;
    i_sw_addr <= a;
    i_sw_wdata <= d;
    @(posedge i_ref_clk);
    i_sw_we <= 1'b0;
    #1;
  endtask

  task automatic sw_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_sw_re <= 1'b1;
    i_sw_addr <= a;
    @(posedge i_ref_clk);
    i_sw_re <= 1'b0;
    #1;
    d = o_sw_rdata;
  endtask

  initial begin
    #160000;
    miscompares++;
    wrap_up();
  end

  initial begin
    int na;
    int nb;
    logic [7:0] v;
    logic [7:0] r;
    logic [7:0] acc0;
    logic [6:0] ad;
    logic d;
    logic z0;
    logic zr;
    dadi_op_e op;
    void'($urandom(21));
    repeat (8) @(posedge i_ref_clk);
    i_rstn <= 1'b1;
    #1;
    check(o_acc, 8'h00, "acc after reset");
    check({6'h00, o_ready, o_discard}, 8'h02, "ready after reset");
    // Decimal adjust right after addition, interrupts masked around it
    for (int i = 0; i < 24; i++) begin
      na = (i < 4) ? ca[i] : int'($urandom_range(99));
      nb = (i < 4) ? cb[i] : int'($urandom_range(99));
      issue(OP_GLOBAL_IRQ_OFF, 8'h00, 7'h00, 1'b0);
      sw_write(REG_ACC, to_bcd(na));
      issue2(OP_ADD_ACC_REG, OP_DECIMAL_ADJUST_ACC, to_bcd(nb));
      check({7'h00, o_gie}, 8'h00, "irq off");
      check(o_acc, to_bcd((na + nb) % 100), "adjust value");
      check({7'h00, o_flag_c}, 8'((na + nb) > 99), "adjust carry");
      check({7'h00, o_flag_hc}, 8'(((na % 10) + (nb % 10)) > 15), "add half carry");
      issue(OP_GLOBAL_IRQ_ON, 8'h00, 7'h00, 1'b0);
      check({7'h00, o_gie}, 8'h01, "irq on");
    end
    // Decrement and decrement-skip, both destinations, wrap and zero corners
    for (int i = 0; i < 40; i++) begin
      op = i[0] ? OP_DECREMENT_SKIP_ZERO : OP_DECREMENT_REG;
      v = (i < 8) ? 8'(i[2:1]) : 8'($urandom);
      ad = (i == 3) ? 7'h7f : 7'($urandom);
      d = (i < 8) ? i[3] ^ i[1] : 1'($urandom);
      zr = ((v - 8'h01) == 8'h00);
      z0 = o_flag_z;
      acc0 = o_acc;
      issue(op, v, ad, d);
      check(o_acc, d ? acc0 : v - 8'h01, "dec to acc");
      check({7'h00, o_rf_we}, 8'(d), "dec rf write");
      check({1'b0, o_rf_addr}, {1'b0, ad}, "dec rf addr");
      if (d) begin
        check(o_rf_wdata, v - 8'h01, "dec rf data");
      end
      if (op == OP_DECREMENT_REG) begin
        check({7'h00, o_flag_z}, 8'(zr), "dec zero flag");
        check({6'h00, o_ready, o_discard}, 8'h02, "dec one cycle");
      end else begin
        check({7'h00, o_flag_z}, 8'(z0), "skip keeps zero");
        check({6'h00, o_ready, o_discard}, zr ? 8'h01 : 8'h02, "skip slot");
      end
      @(posedge i_ref_clk);
      #1;
      check({5'h00, o_ready, o_discard, o_rf_we}, 8'h04, "slot over");
    end
    // Instruction in the discarded slot has no effect
    issue(OP_GLOBAL_IRQ_OFF, 8'h00, 7'h00, 1'b0);
    issue2(OP_DECREMENT_SKIP_ZERO, OP_GLOBAL_IRQ_ON, 8'h01);
    check({7'h00, o_gie}, 8'h00, "discarded op");
    check({7'h00, o_ready}, 8'h01, "ready after skip");
    check(o_acc, 8'h00, "skip to acc");
    issue(OP_GLOBAL_IRQ_ON, 8'h00, 7'h00, 1'b0);
    sw_read(REG_GIE, r);
    check(r, 8'h01, "gie read");
    issue(OP_GLOBAL_IRQ_OFF, 8'h00, 7'h00, 1'b0);
    sw_read(REG_GIE, r);
    check(r, 8'h00, "gie read off");
    sw_write(REG_STATUS, 8'h05);
    check({5'h00, o_flag_hc, o_flag_c, o_flag_z}, 8'h05, "status flags");
    sw_read(REG_STATUS, r);
    check(r, 8'h05, "status read");
    sw_write(REG_GIE, 8'hff);
    check({7'h00, o_gie}, 8'h01, "gie write");
    sw_write(REG_ACC, 8'h5a);
    sw_read(REG_ACC, r);
    check(r, 8'h5a, "acc read");
    for (int a = 3; a < 16; a++) begin
      sw_read(4'(a), r);
      check(r, 8'h00, "unmapped read");
    end
    wrap_up();
  end
endmodule
`default_nettype wire
